// >>> src/urx_ctrl.sv
/*
  Receive control of one OUT endpoint with DMA channel routing, APB slave.
  Assumes the receive engine, endpoint configuration and DMA run on pclk,
  so their signals need no synchroniser; the token decision is combinational.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
// Overview of operation
// - Flag warning when free bytes below limit
// - Limit codes: off, under 5, under 17
// - Flush empties FIFO, pointers, idle state
// - Flush waits while packet is received
// - Skip SETUP tokens when bit set
// - Packet or OUT stall clears receive enable
// - SETUP accepted whatever receive enable says
// - Repeated SETUP discarded but still ACKed
// - Otherwise unacceptable SETUP gets no handshake
// - DMA enable low leaves endpoints unrouted
// - DMA enable high routes both channels
// - Transmit select picks endpoint 1,3,5
// - Receive select picks endpoint 2,4,6
// - Disabled endpoint answers no token
module urx_ctrl
  import urx_pkg::*;
#(
  parameter int FREE_W = 7
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        ep_addr,
  input  wire logic              endpoint_active,
  input  wire logic              ep_stall,
  input  wire urx_token_type     token,
  input  wire logic              rx_busy,
  input  wire logic              rx_setup_room,
  input  wire logic              rx_packet_done,
  input  wire logic [FREE_W-1:0] fifo_free,
  output urx_reply_type          reply,
  output logic                   fifo_flush,
  output urx_route_type          dma0_route,
  output urx_route_type          dma1_route,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Select code to endpoint; reserved codes give no route
  function automatic urx_route_type route_of(input logic [2:0] code, input logic [3:0] ep_a,
                                             input logic [3:0] ep_b, input logic [3:0] ep_c);
    urx_route_type r;
    r = '0;
    case (code)
      URX_SEL_A: r = '{valid: 1'b1, ep: ep_a};
      URX_SEL_B: r = '{valid: 1'b1, ep: ep_b};
      URX_SEL_C: r = '{valid: 1'b1, ep: ep_c};
      default:   r = '0;
    endcase
    return r;
  endfunction : route_of

  // Register index match on the decoded address bits
  function automatic logic idx_hit(input logic [11:0] a, input logic [31:0] idx);
    return a[11:2] == idx[URX_DEC_W-1:0];
  endfunction : idx_hit

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic                rx_en_r;
  logic                skip_setup_tokens_r;
  logic                flush_pend_r;
  logic [1:0]          rx_fifo_warn_limit_r;
  logic                dma_en_r;
  logic [2:0]          dma_tx_sel_r;
  logic [2:0]          dma_rx_sel_r;
  logic [URX_EV_W-1:0] ev_stat_r;
  logic [URX_EV_W-1:0] ev_mask_r;
  logic                setup_held_r;
  logic [31:0]         prdata_r;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire logic          acc      = psel & penable;
  wire logic          wr       = acc & pwrite;
  wire logic          hit_ctl  = idx_hit(paddr, URX_RXCTRL_IDX);
  wire logic          hit_dma  = idx_hit(paddr, URX_DMARTE_IDX);
  wire logic          hit_st   = idx_hit(paddr, URX_EVSTAT_IDX);
  wire logic          hit_mk   = idx_hit(paddr, URX_EVMASK_IDX);
  wire logic          mapped   = hit_ctl | hit_dma | hit_st | hit_mk;
  wire logic          wr_ctl   = wr & hit_ctl;
  wire logic          wr_dma   = wr & hit_dma;
  wire logic          wr_st    = wr & hit_st;
  wire logic          wr_mk    = wr & hit_mk;

  // Read views, reserved bits zero
  wire logic [31:0] ctl_view = {25'h000_0000, rx_fifo_warn_limit_r, 1'b0, flush_pend_r,
                                skip_setup_tokens_r, 1'b0, rx_en_r};
  wire logic [31:0] dma_view = {25'h000_0000, dma_en_r, dma_tx_sel_r, dma_rx_sel_r};
  wire logic [31:0] rd_mux   = hit_ctl ? ctl_view :
                               hit_dma ? dma_view :
                               hit_st  ? {28'h000_0000, ev_stat_r} :
                               hit_mk  ? {28'h000_0000, ev_mask_r} : 32'h0000_0000;

  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = prdata_r;

  // Read data captured in the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_r <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // Token decision
  // ----------------------------------------------------------------------
  wire logic ours       = token.valid & endpoint_active & (token.ep == ep_addr);
  wire logic is_setup   = ours & (token.kind == URX_TOK_SETUP);
  wire logic is_out     = ours & (token.kind == URX_TOK_OUT);
  wire logic setup_take = is_setup & ~skip_setup_tokens_r;
  wire logic setup_dup  = setup_take & setup_held_r;
  wire logic setup_ok   = setup_take & ~setup_held_r & ~rx_busy & rx_setup_room;
  wire logic out_stall  = is_out & ep_stall;
  wire logic out_ok     = is_out & ~ep_stall & rx_en_r;

  // Reply: SETUP ignores receive enable refused SETUP is silent
  // Priority keeps a repeated SETUP on ACK even when the FIFO has no room
  always_comb begin
    reply = '0;
    if (setup_dup) begin
      reply = '{respond: 1'b1, accept: 1'b0, discard: 1'b1, hs: URX_HS_ACK};
    end else if (setup_ok) begin
      reply = '{respond: 1'b1, accept: 1'b1, discard: 1'b0, hs: URX_HS_ACK};
    end else if (setup_take) begin
      reply = '{respond: 1'b1, accept: 1'b0, discard: 1'b1, hs: URX_HS_NONE};
    end else if (out_stall) begin
      reply = '{respond: 1'b1, accept: 1'b0, discard: 1'b1, hs: URX_HS_STALL};
    end else if (out_ok) begin
      reply = '{respond: 1'b1, accept: 1'b1, discard: 1'b0, hs: URX_HS_ACK};
    end else if (is_out) begin
      reply = '{respond: 1'b1, accept: 1'b0, discard: 1'b1, hs: URX_HS_NAK};
    end
  end

  // A valid SETUP is held until any non-SETUP token for this endpoint
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) setup_held_r <= 1'b0;
    else if (setup_ok) setup_held_r <= 1'b1;
    else if (ours && token.kind != URX_TOK_SETUP) setup_held_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Receive control register
  // ----------------------------------------------------------------------
  wire logic rx_en_clr = rx_packet_done | out_stall;
  wire logic rx_en_set = wr_ctl & pwdata[URX_RXEN_BIT];

  // Firmware re-arm wins over a same-cycle clear so the write is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en_r              <= URX_RXCTRL_RST[URX_RXEN_BIT];
      skip_setup_tokens_r  <= URX_RXCTRL_RST[URX_SKIPSU_BIT];
      rx_fifo_warn_limit_r <= URX_RXCTRL_RST[URX_WLIM_LSB +: 2];
    end else begin
      if (rx_en_set) rx_en_r <= 1'b1;
      else if (rx_en_clr) rx_en_r <= 1'b0;
      if (wr_ctl) begin
        skip_setup_tokens_r  <= pwdata[URX_SKIPSU_BIT];
        rx_fifo_warn_limit_r <= pwdata[URX_WLIM_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flush: pending until the receive engine is idle
  // ----------------------------------------------------------------------
  assign fifo_flush = flush_pend_r & ~rx_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flush_pend_r <= URX_RXCTRL_RST[URX_FLUSH_BIT];
    else if (wr_ctl && pwdata[URX_FLUSH_BIT]) flush_pend_r <= 1'b1;
    else if (fifo_flush) flush_pend_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // FIFO warning
  // ----------------------------------------------------------------------
  // Limit code 11 matches neither compare, so it behaves as disabled
  wire logic warn_low  = (rx_fifo_warn_limit_r == URX_WLIM_LOW) &
                         (fifo_free < FREE_W'(URX_WARN_LOW));
  wire logic warn_high = (rx_fifo_warn_limit_r == URX_WLIM_HIGH) &
                         (fifo_free < FREE_W'(URX_WARN_HIGH));
  wire logic warn_hit  = warn_low | warn_high;

  // ----------------------------------------------------------------------
  // Event status (write one to clear, set wins) and mask
  // ----------------------------------------------------------------------
  wire logic [URX_EV_W-1:0] ev_set = {fifo_flush, setup_ok, rx_packet_done, warn_hit};
  wire logic [URX_EV_W-1:0] ev_clr = wr_st ? pwdata[URX_EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_r <= '0;
      ev_mask_r <= '0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
      if (wr_mk) ev_mask_r <= pwdata[URX_EV_W-1:0];
    end
  end

  assign irq = |(ev_stat_r & ev_mask_r);

  // ----------------------------------------------------------------------
  // DMA routing
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_en_r     <= URX_DMARTE_RST[URX_DEN_BIT];
      dma_tx_sel_r <= URX_DMARTE_RST[URX_DTX_LSB +: 3];
      dma_rx_sel_r <= URX_DMARTE_RST[URX_DRX_LSB +: 3];
    end else if (wr_dma) begin
      dma_en_r     <= pwdata[URX_DEN_BIT];
      dma_tx_sel_r <= pwdata[URX_DTX_LSB +: 3];
      dma_rx_sel_r <= pwdata[URX_DRX_LSB +: 3];
    end
  end

  // Channel 0 serves receive, channel 1 transmit; off means unrouted
  // Reserved select codes give an invalid route rather than a wrong one
  wire urx_route_type rx_pick = route_of(dma_rx_sel_r, URX_RX_EP_A, URX_RX_EP_B,
                                         URX_RX_EP_C);
  wire urx_route_type tx_pick = route_of(dma_tx_sel_r, URX_TX_EP_A, URX_TX_EP_B,
                                         URX_TX_EP_C);
  assign dma0_route = dma_en_r ? rx_pick : '0;
  assign dma1_route = dma_en_r ? tx_pick : '0;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All on pclk, quiet while presetn holds the block in reset
  warn_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    warn_hit |=> ev_stat_r[URX_EV_WARN]) else $error("warning flag not set");

  warn_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_fifo_warn_limit_r == URX_WLIM_LOW && fifo_free == FREE_W'(4)) |-> warn_hit)
    else $error("warning limit decode wrong");

  flush_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_busy |-> !fifo_flush) else $error("flush while receiving");

  flush_issue_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && pwdata[URX_FLUSH_BIT] && !rx_busy) ##1 !rx_busy |-> fifo_flush)
    else $error("flush not issued");

  skip_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    (is_setup && skip_setup_tokens_r) |-> !reply.respond)
    else $error("skipped setup answered");

  rx_en_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_packet_done && !rx_en_set) |=> !rx_en_r ##0 !out_ok)
    else $error("receive enable not cleared");

  setup_any_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ok && !rx_en_r) |-> reply.accept && reply.hs == URX_HS_ACK)
    else $error("setup refused by receive enable");

  dup_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ok ##1 setup_take) |-> reply.discard && reply.hs == URX_HS_ACK)
    else $error("repeated setup not discarded with ACK");

  setup_silent_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_take && !setup_held_r && rx_busy) |-> reply.hs == URX_HS_NONE)
    else $error("refused setup handshaken");

  dma_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dma_en_r |-> !dma0_route.valid && !dma1_route.valid)
    else $error("route while dma off");

  dma_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_dma && pwdata[6:0] == 7'h49) |=> dma1_route.ep == URX_TX_EP_B
    && dma0_route.ep == URX_RX_EP_B) else $error("dma route wrong");

  ep_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !endpoint_active |-> !reply.respond) else $error("disabled endpoint answered");

  rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && hit_ctl) |->
    prdata[31:7] == '0 && prdata[4] == 1'b0 && prdata[1] == 1'b0)
    else $error("reserved bits not zero");

endmodule : urx_ctrl

// >>> common/urx_pkg.sv
/*
  Shared constants and types of the OUT endpoint receive control block:
  register indices, field positions, reset values and the carrier structs.
  Assumes a 32-bit APB with word-aligned registers; byte address = 4 x index.
*/
package urx_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [31:0] URX_RXCTRL_IDX = 32'h5000_187e; // endpoint3_receive_control
  localparam logic [31:0] URX_DMARTE_IDX = 32'h5000_18d0; // serial_bus_dma_routing
  localparam logic [31:0] URX_EVSTAT_IDX = 32'h5000_18e0; // fifo_warning_events + events
  localparam logic [31:0] URX_EVMASK_IDX = 32'h5000_18e1; // event mask
  localparam int          URX_DEC_W      = 10;            // index bits decoded

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int URX_RXEN_BIT   = 0;
  localparam int URX_SKIPSU_BIT = 2;
  localparam int URX_FLUSH_BIT  = 3;
  localparam int URX_WLIM_LSB   = 5;
  localparam int URX_DRX_LSB    = 0;
  localparam int URX_DTX_LSB    = 3;
  localparam int URX_DEN_BIT    = 6;
  localparam int URX_EV_WARN    = 0;  // rx_fifo_warn_flag
  localparam int URX_EV_PKT     = 1;  // data packet received
  localparam int URX_EV_SETUP   = 2;  // setup packet accepted
  localparam int URX_EV_FLUSH   = 3;  // flush carried out
  localparam int URX_EV_W       = 4;

  // ----------------------------------------------------------------------
  // Reset values and decode figures
  // ----------------------------------------------------------------------
  localparam logic [15:0] URX_RXCTRL_RST = 16'h0000;
  localparam logic [15:0] URX_DMARTE_RST = 16'h0000;
  localparam logic [1:0]  URX_WLIM_OFF   = 2'h0;
  localparam logic [1:0]  URX_WLIM_LOW   = 2'h1;
  localparam logic [1:0]  URX_WLIM_HIGH  = 2'h2;
  localparam int          URX_WARN_LOW   = 5;   // fewer than 5 bytes free
  localparam int          URX_WARN_HIGH  = 17;  // fewer than 17 bytes free
  localparam logic [2:0]  URX_SEL_A      = 3'h0;
  localparam logic [2:0]  URX_SEL_B      = 3'h1;
  localparam logic [2:0]  URX_SEL_C      = 3'h2;
  localparam logic [3:0]  URX_TX_EP_A    = 4'h1;
  localparam logic [3:0]  URX_TX_EP_B    = 4'h3;
  localparam logic [3:0]  URX_TX_EP_C    = 4'h5;
  localparam logic [3:0]  URX_RX_EP_A    = 4'h2;
  localparam logic [3:0]  URX_RX_EP_B    = 4'h4;
  localparam logic [3:0]  URX_RX_EP_C    = 4'h6;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {URX_TOK_OUT, URX_TOK_SETUP, URX_TOK_IN, URX_TOK_OTHER}
    urx_tok_kind_type;
  typedef enum logic [1:0] {URX_HS_NONE, URX_HS_ACK, URX_HS_NAK, URX_HS_STALL}
    urx_hs_type;

  typedef struct packed {
    logic             valid;
    urx_tok_kind_type kind;
    logic [3:0]       ep;
  } urx_token_type;

  typedef struct packed {
    logic       respond;  // token is ours and answered
    logic       accept;   // store the data packet
    logic       discard;  // drop the data packet
    urx_hs_type hs;
  } urx_reply_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] ep;
  } urx_route_type;

endpackage : urx_pkg

// >>> dv/urx_host_model.sv
/*
  Host and receive engine model: issues tokens and data packets.
  Assumes one pclk domain; the bench calls send_token by path.
*/
`timescale 1ns/1ns
module urx_host_model
  import urx_pkg::*;
(
  input  wire logic          pclk,
  input  wire urx_reply_type reply,
  output urx_token_type      token,
  output logic               rx_busy,
  output logic               rx_packet_done
);
  // ----------------------------------------------------------------------
  // Idle bus and token task
  // ----------------------------------------------------------------------
  // Idle values at time zero
  initial begin
    token = '0;
    rx_busy = 1'b0;
    rx_packet_done = 1'b0;
  end

  // One token cycle; an accepted token brings a packet after gap cycles
  task automatic send_token(input urx_tok_kind_type kind, input logic [3:0] ep,
                            input int gap, output urx_reply_type seen);
    token <= '{valid: 1'b1, kind: kind, ep: ep};
    @(posedge pclk);
    seen = reply;
    token <= '{valid: 1'b0, kind: URX_TOK_OTHER, ep: ~ep}; // Stale fields scrambled
    if (seen.accept) begin
      rx_busy <= 1'b1;
      repeat (gap) @(posedge pclk);
      rx_busy <= 1'b0;
      rx_packet_done <= 1'b1;
      @(posedge pclk);
      rx_packet_done <= 1'b0;
    end
    @(posedge pclk);
  endtask : send_token
endmodule : urx_host_model

// >>> dv/urx_ctrl_bench.sv
/*
  Self-checking bench of the OUT endpoint receive control block.
  Assumes urx_host_model on the token side and the APB slave of urx_ctrl.
*/
`timescale 1ns/1ns
module urx_ctrl_bench
  import urx_pkg::*;
;
  localparam logic [11:0] A_CTRL = {URX_RXCTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] A_DMA  = {URX_DMARTE_IDX[9:0], 2'b00};
  localparam logic [11:0] A_STAT = {URX_EVSTAT_IDX[9:0], 2'b00};
  localparam logic [11:0] A_MASK = {URX_EVMASK_IDX[9:0], 2'b00};
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          endpoint_active;
  logic          ep_stall;
  logic          rx_setup_room;
  logic [6:0]    fifo_free;
  urx_token_type token;
  logic          rx_busy;
  logic          rx_packet_done;
  urx_reply_type reply;
  urx_reply_type seen;
  logic          fifo_flush;
  urx_route_type dma0_route;
  urx_route_type dma1_route;
  logic          irq;
  logic [31:0]   rd;
  logic          err;
  int            mismatches = 0;
  int            checks = 0;
  int            flushes = 0;
  int            cycles = 0;
  logic [1:0]    wl [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  logic [6:0]    wf [5] = '{7'd5, 7'd4, 7'd17, 7'd16, 7'd0};
  logic          we [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  // ----------------------------------------------------------------------
  // Design, host model, clock and watchers
  // ----------------------------------------------------------------------
  urx_ctrl #(.FREE_W(7)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ep_addr(4'h3),
    .endpoint_active(endpoint_active), .ep_stall(ep_stall), .token(token),
    .rx_busy(rx_busy), .rx_setup_room(rx_setup_room),
    .rx_packet_done(rx_packet_done), .fifo_free(fifo_free), .reply(reply),
    .fifo_flush(fifo_flush), .dma0_route(dma0_route), .dma1_route(dma1_route),
    .irq(irq));
  urx_host_model host_u (.pclk(pclk), .reply(reply), .token(token),
    .rx_busy(rx_busy), .rx_packet_done(rx_packet_done));

  // Clock of 10 ns
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Flush pulse count and hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (fifo_flush === 1'b1) begin
      flushes++;
    end
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & m, e);
  endtask : rdchk

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, ep_stall} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {endpoint_active, rx_setup_room} = 2'b11;
    fifo_free = 7'h7f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(A_CTRL, '1, 32'h0000_0000);
    rdchk(A_DMA, '1, 32'h0000_0000);
    rdchk(A_STAT, '1, 32'h0000_0000);
    apb(1'b1, A_CTRL, 32'hffff_fff6);
    rdchk(A_CTRL, '1, 32'h0000_0064);
    apb(1'b1, A_DMA, 32'hffff_ff80);
    rdchk(A_DMA, '1, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    // Routing codes in use only; reserved codes stay unwritten
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_DMA, 32'h0000_0040 + 32'(9 * i));
      check(dma0_route, 32'h10 + 32'(2 + 2 * i));
      check(dma1_route, 32'h10 + 32'(1 + 2 * i));
    end
    apb(1'b1, A_DMA, 32'h0000_0012);
    check({dma0_route.valid, dma1_route.valid}, 32'h0);
    // Warning limits, free space on both sides of each bound
    apb(1'b1, A_MASK, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      fifo_free <= 7'h7f;
      apb(1'b1, A_CTRL, {25'h0, wl[i], 5'h00});
      apb(1'b1, A_STAT, 32'h0000_000f);
      fifo_free <= wf[i];
      repeat (2) @(posedge pclk);
      check(irq, we[i]);
      rdchk(A_STAT, 32'h1, {31'h0, we[i]});
    end
    apb(1'b1, A_MASK, 32'h0000_0000);
    apb(1'b1, A_STAT, 32'h0000_000f);
    // Receive enable handshake, SETUP handling
    host_u.send_token(URX_TOK_OUT, 4'h3, 0, seen);
    check(seen.hs, URX_HS_NAK);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    host_u.send_token(URX_TOK_OUT, 4'h3, 2, seen);
    check({seen.accept, seen.hs}, {1'b1, URX_HS_ACK});
    rdchk(A_CTRL, 32'h1, 32'h0);
    host_u.send_token(URX_TOK_SETUP, 4'h3, 1, seen);
    check({seen.accept, seen.hs}, {1'b1, URX_HS_ACK});
    host_u.send_token(URX_TOK_SETUP, 4'h3, 1, seen);
    check({seen.accept, seen.discard, seen.hs}, {2'b01, URX_HS_ACK});
    host_u.send_token(URX_TOK_OUT, 4'h3, 0, seen);
    rx_setup_room <= 1'b0;
    host_u.send_token(URX_TOK_SETUP, 4'h3, 1, seen);
    check({seen.accept, seen.hs}, {1'b0, URX_HS_NONE});
    rx_setup_room <= 1'b1;
    rdchk(A_STAT, 32'h6, 32'h6);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    ep_stall <= 1'b1;
    host_u.send_token(URX_TOK_OUT, 4'h3, 0, seen);
    check(seen.hs, URX_HS_STALL);
    ep_stall <= 1'b0;
    rdchk(A_CTRL, 32'h1, 32'h0);
    apb(1'b1, A_CTRL, 32'h0000_0004);
    host_u.send_token(URX_TOK_SETUP, 4'h3, 1, seen);
    check(seen.respond, 1'b0);
    endpoint_active <= 1'b0;
    apb(1'b1, A_CTRL, 32'h0000_0001);
    host_u.send_token(URX_TOK_OUT, 4'h3, 1, seen);
    check(seen.respond, 1'b0);
    endpoint_active <= 1'b1;
    // Flush requested in the middle of a slow packet
    fork
      host_u.send_token(URX_TOK_OUT, 4'h3, 20, seen);
      begin
        apb(1'b1, A_CTRL, 32'h0000_0008);
        check(flushes, 0);
        rdchk(A_CTRL, 32'h8, 32'h8);
      end
    join
    repeat (3) @(posedge pclk);
    check(flushes, 1);
    rdchk(A_STAT, 32'h8, 32'h8);
    rdchk(A_CTRL, 32'h8, 32'h0);
    report_and_stop();
  end
endmodule : urx_ctrl_bench
